// ### ppc_top.sv
// port pin cell block: mode registers, crossbar, pad drive and events
//
// Decided for this implementation: the address map and the strobed register port.
`include "ppc_consts.svh"
module ppc_top (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire ppc_pkg::ppc_byte_t i_addr,
  input wire ppc_pkg::ppc_byte_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output ppc_pkg::ppc_byte_t o_rdata,
  input wire ppc_pkg::ppc_pins_t i_pad_in,
  output ppc_pkg::ppc_pins_t o_pad_out,
  output ppc_pkg::ppc_pins_t o_pad_oe_n,
  output ppc_pkg::ppc_pins_t o_pad_pullup,
  output ppc_pkg::ppc_pins_t o_analog_sw,
  input wire ppc_pkg::ppc_sigs_t i_periph_out,
  output ppc_pkg::ppc_sigs_t o_periph_in,
  input wire logic i_vref_en,
  input wire logic i_idac_a_en,
  input wire logic i_xtal_en,
  input wire logic i_xosc_en,
  output logic o_int0_event,
  output logic o_int1_event,
  output logic o_match_event,
  output logic o_port_match,
  output logic o_wake
);
  import ppc_pkg::*;

  // ************************************************************
  // register file
  // ************************************************************
  localparam logic [7:0] GRP_BASE [4] = '{`PPC_OFS_IN_MODE,
    `PPC_OFS_OUT_MODE, `PPC_OFS_SKIP, `PPC_OFS_LATCH};
  localparam logic [7:0] GRP_RST [4] = '{`PPC_RST_DIGITAL,
    `PPC_RST_ZERO, `PPC_RST_ZERO, `PPC_RST_LATCH};
  localparam logic [7:0] PAD_BASE = `PPC_OFS_PAD;
  localparam ppc_sigs_t SIG_OUT = `PPC_SIG_OUT;
  localparam ppc_sigs_t SIG_OD = `PPC_SIG_OD;

  ppc_pins_t cfg_v [4];
  ppc_byte_t route_a;
  ppc_byte_t route_b;
  ppc_byte_t int_sel;
  ppc_byte_t m_mask [2];
  ppc_byte_t m_val [2];
  ppc_pins_t in_mode_v;
  ppc_pins_t out_mode_v;
  ppc_pins_t skip_v;
  ppc_pins_t latch_v;
  ppc_pins_t pad_sync;
  ppc_pins_t pad_rd;
  ppc_pins_t fixed_an;
  ppc_pins_t pin_used;
  ppc_sig_idx_t pin_sig [`PPC_NPIN];
  ppc_sigs_t sig_ok;
  ppc_pin_idx_t sig_pin [`PPC_NSIG];
  ppc_sigs_t sig_en;
  ppc_byte_t next_rdata;
  logic xbar_en;
  logic wpud;
  wire [`PPC_NPIN-1:0] next_oe_n;
  wire [`PPC_NPIN-1:0] next_out;
  wire [`PPC_NPIN-1:0] next_pu;
  wire [`PPC_NSIG-1:0] next_pin_in;

  // port register hit: three ports per group, fourth slot unmapped
  function automatic logic port_hit(input ppc_byte_t a,
                                    input ppc_byte_t base);
    port_hit = (a[7:2] == base[7:2]) && (a[1:0] != 2'h3);
  endfunction

  // one port byte of a pin vector, unused upper port bits read 0
  function automatic ppc_byte_t port_byte(input ppc_pins_t v,
                                          input logic [1:0] k);
    logic [23:0] w;
    w = {3'h0, v};
    port_byte = w[k*8 +: 8];
  endfunction

  // per-port configuration groups: input mode, output mode, skip, latch
  for (genvar g = 0; g < 4; g++) begin : g_cfg
    ppc_byte_t r [3];
    always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
        for (int k = 0; k < 3; k++) begin
          r[k] <= GRP_RST[g];
        end
      end else if (i_wr && port_hit(i_addr, GRP_BASE[g])) begin
        r[i_addr[1:0]] <= i_wdata;
      end
    end
    wire [23:0] flat = {r[2], r[1], r[0]};
    assign cfg_v[g] = flat[`PPC_NPIN-1:0];
  end

  assign in_mode_v = cfg_v[0];
  assign out_mode_v = cfg_v[1];
  assign skip_v = cfg_v[2];
  assign latch_v = cfg_v[3];

  // routing selects, crossbar enable and pull-up disable
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      route_a <= `PPC_RST_ZERO;
      route_b <= `PPC_RST_ZERO;
    end else if (i_wr) begin
      if (i_addr == `PPC_OFS_ROUTE_A) begin
        route_a <= i_wdata;
      end
      if (i_addr == `PPC_OFS_ROUTE_B) begin
        route_b <= i_wdata;
      end
    end
  end

  // external interrupt pin and polarity select
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      int_sel <= `PPC_RST_ZERO;
    end else if (i_wr && i_addr == `PPC_OFS_INT_SEL) begin
      int_sel <= i_wdata;
    end
  end

  // port match mask and value, ports 0 and 1
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < 2; k++) begin
        m_mask[k] <= `PPC_RST_ZERO;
        m_val[k] <= `PPC_RST_ZERO;
      end
    end else if (i_wr) begin
      case (i_addr)
        `PPC_OFS_M0_MASK: m_mask[0] <= i_wdata;
        `PPC_OFS_M0_VAL: m_val[0] <= i_wdata;
        `PPC_OFS_M1_MASK: m_mask[1] <= i_wdata;
        `PPC_OFS_M1_VAL: m_val[1] <= i_wdata;
        default: ;
      endcase
    end
  end

  assign xbar_en = route_b[`PPC_RB_XBAR_EN];
  assign wpud = route_b[`PPC_RB_WPUD];

  // read mux, data valid in the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    for (int g = 0; g < 4; g++) begin
      if (port_hit(i_addr, GRP_BASE[g])) begin
        next_rdata = port_byte(cfg_v[g], i_addr[1:0]);
      end
    end
    if (port_hit(i_addr, PAD_BASE)) begin
      next_rdata = port_byte(pad_rd, i_addr[1:0]);
    end
    case (i_addr)
      `PPC_OFS_ROUTE_A: next_rdata = route_a;
      `PPC_OFS_ROUTE_B: next_rdata = route_b;
      `PPC_OFS_INT_SEL: next_rdata = int_sel;
      `PPC_OFS_M0_MASK: next_rdata = m_mask[0];
      `PPC_OFS_M0_VAL: next_rdata = m_val[0];
      `PPC_OFS_M1_MASK: next_rdata = m_mask[1];
      `PPC_OFS_M1_VAL: next_rdata = m_val[1];
      default: ;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? next_rdata : '0;
    end
  end

  // ************************************************************
  // pad input and crossbar
  // ************************************************************
  // pad levels are asynchronous to the system clock
  ppc_sync #(.WIDTH(`PPC_NPIN)) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_d(i_pad_in),
    .o_q(pad_sync)
  );

  // analog pins read 0, digital pins the sensed pad
  assign pad_rd = pad_sync & in_mode_v;

  // pins held by fixed analog functions
  always_comb begin
    fixed_an = '0;
    fixed_an[`PPC_PIN_VREF] = i_vref_en;
    fixed_an[`PPC_PIN_IDAC_A] = i_idac_a_en;
    fixed_an[`PPC_PIN_XTAL_IN] = i_xtal_en;
    fixed_an[`PPC_PIN_XTAL_OUT] = i_xtal_en | i_xosc_en;
  end

  // signal enables in priority order
  always_comb begin
    sig_en = '0;
    sig_en[1:0] = {2{route_a[`PPC_RA_UART]}};
    sig_en[4:2] = {3{route_a[`PPC_RA_SPI]}};
    sig_en[6:5] = {2{route_a[`PPC_RA_SMB0]}};
    sig_en[8:7] = {2{route_a[`PPC_RA_SMB1]}};
    sig_en[9] = route_a[`PPC_RA_CP0];
    sig_en[10] = route_a[`PPC_RA_COMPARATOR_ASYNC_OUT];
    sig_en[11] = route_a[`PPC_RA_SYSTEM_CLOCK_OUT];
    sig_en[15:12] = route_b[3:0];
  end

  ppc_xbar u_xbar (
    .i_sig_en(sig_en),
    .i_skip(skip_v),
    .o_pin_used(pin_used),
    .o_pin_sig(pin_sig),
    .o_sig_ok(sig_ok),
    .o_sig_pin(sig_pin)
  );

  // ************************************************************
  // pad cells
  // ************************************************************
  for (genvar p = 0; p < `PPC_NPIN; p++) begin : g_pin
    wire ppc_sig_idx_t sig = pin_sig[p];
    wire sel = pin_used[p];
    wire is_out = sel & SIG_OUT[sig];
    wire val = is_out ? i_periph_out[sig] : latch_v[p];
    wire od = !out_mode_v[p] | (sel & SIG_OD[sig]);
    wire dig = in_mode_v[p] & !fixed_an[p];
    // push-pull drives both ways, open-drain only low
    wire drive = xbar_en & dig & (!sel | is_out)
                 & (!od | !val);
    assign next_oe_n[p] = !drive;
    assign next_out[p] = val & !od;
    assign next_pu[p] = dig & !wpud & !drive;
    assign o_analog_sw[p] = !in_mode_v[p] | fixed_an[p];
  end

  for (genvar s = 0; s < `PPC_NSIG; s++) begin : g_sig
    // routed inputs idle high when not placed
    assign next_pin_in[s] = (sig_ok[s] & xbar_en)
                            ? pad_rd[sig_pin[s]] : 1'b1;
  end

  // registered pad controls and routed inputs
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_pad_oe_n <= '1;
      o_pad_out <= '0;
      o_pad_pullup <= '1;
      o_periph_in <= '1;
    end else begin
      o_pad_oe_n <= next_oe_n;
      o_pad_out <= next_out;
      o_pad_pullup <= next_pu;
      o_periph_in <= next_pin_in;
    end
  end

  // ************************************************************
  // event triggers
  // ************************************************************
  wire [2:0] int0_pin = int_sel[`PPC_IS_PIN0 +: 3];
  wire [2:0] int1_pin = int_sel[`PPC_IS_PIN1 +: 3];
  // analog pins never look active
  wire int0_act = in_mode_v[int0_pin]
                  & (pad_sync[int0_pin] ~^ int_sel[`PPC_IS_POL0]);
  wire int1_act = in_mode_v[int1_pin]
                  & (pad_sync[int1_pin] ~^ int_sel[`PPC_IS_POL1]);
  wire [15:0] m_diff = (pad_rd[15:0] ^ {m_val[1], m_val[0]})
                       & {m_mask[1], m_mask[0]} & in_mode_v[15:0];
  wire next_match = |m_diff;
  logic int0_prev;
  logic int1_prev;

  // edge detect, one-cycle event pulses and wake
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      // held as already active: the synchroniser clears to 0 while pads
      // idle high, which would otherwise look like a fresh edge
      int0_prev <= 1'b1;
      int1_prev <= 1'b1;
      o_port_match <= 1'b0;
      o_int0_event <= 1'b0;
      o_int1_event <= 1'b0;
      o_match_event <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      int0_prev <= int0_act;
      int1_prev <= int1_act;
      o_port_match <= next_match;
      o_int0_event <= int0_act & !int0_prev;
      o_int1_event <= int1_act & !int1_prev;
      o_match_event <= next_match & !o_port_match;
      o_wake <= (int0_act & !int0_prev) | (int1_act & !int1_prev)
                | (next_match & !o_port_match);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence xbar_held_off;
    !xbar_en [*2];
  endsequence

  sequence pad0_steady;
    $stable(i_pad_in[0]) [*4];
  endsequence

  sequence p0_analog;
    (in_mode_v[7:0] == 8'h00) [*3];
  endsequence

  xbar_off_a: assert property (xbar_held_off |-> &o_pad_oe_n)
    else $error("driver on while crossbar disabled");

  pull_low_a: assert property ((o_pad_pullup & ~o_pad_oe_n
      & ~o_pad_out) == '0)
    else $error("pull-up on while driving low");

  wpud_off_a: assert property (wpud |=> o_pad_pullup == '0)
    else $error("pull-up on despite global disable");

  od_high_a: assert property ((xbar_en && !out_mode_v[1]
      && !pin_used[1] && latch_v[1]) |=> o_pad_oe_n[1])
    else $error("open-drain pin driven while high");

  pp_drive_a: assert property ((xbar_en && out_mode_v[0]
      && in_mode_v[0] && !pin_used[0] && !fixed_an[0])
      |=> (!o_pad_oe_n[0] && o_pad_out[0] == $past(latch_v[0])))
    else $error("push-pull pin not driving its value");

  analog_read_a: assert property ((i_rd && i_addr == PAD_BASE
      && !in_mode_v[0]) |=> !o_rdata[0])
    else $error("analog pin read not zero");

  pad_read_a: assert property ((pad0_steady ##0 (i_rd
      && in_mode_v[0] && i_addr == PAD_BASE))
      |=> o_rdata[0] == $past(i_pad_in[0], 2))
    else $error("pad read differs from pad level");

  analog_evt_a: assert property ((p0_analog
      ##0 (int_sel == 8'h00)) |=> (!o_int0_event && !o_int1_event))
    else $error("event on an analog pin");

  uart_fixed_a: assert property (sig_en[0] |-> (pin_used[4]
      && pin_sig[4] == 4'h0 && pin_used[5]))
    else $error("first uart not on fixed pins");

  skip_free_a: assert property ((pin_used & skip_v
      & ~(sig_en[0] ? 21'h000030 : 21'h000000)) == '0)
    else $error("crossbar claimed a skipped pin");

endmodule // ppc_top

// ### ppc_consts.svh
// constants for the port pin cell block: offsets, fields, resets, maps
//
// Contract
// - digital input mode bit 1 serves digital uses
// - push-pull drives pad to output value
// - open-drain drives low only, else off
// - pull-up on when high-z, off driving
// - global pull-up disable kills all pull-ups
// - digital pin reads the sensed pad level
// - skipped pin never claimed by crossbar; first uart still takes P0.4/P0.5 if skipped
// - fixed analog pins P0.0 to P0.3
// - routed functions use unskipped P0.0-P2.3 only; first uart takes P0.4/P0.5 even if skipped
// - first uart always sits on P0.4/P0.5
// - pin transition raises event or wake
// - events work skipped or routed, never analog
// - ext ints on P0, port match P0-P1
// - analog pin: no pull, driver, receiver; reads 0
// - crossbar disabled keeps all drivers off
// - crossbar gives lowest free unskipped pin
// - two-wire bus pins always open-drain
`ifndef PPC_CONSTS_SVH
`define PPC_CONSTS_SVH
// ************************************************************
// sizes
// ************************************************************
`define PPC_NPIN 21
`define PPC_NXBAR 20
`define PPC_NSIG 16
// ************************************************************
// register offsets (byte addresses, port n at base + n)
// ************************************************************
`define PPC_OFS_IN_MODE 8'h00
`define PPC_OFS_OUT_MODE 8'h04
`define PPC_OFS_SKIP 8'h08
`define PPC_OFS_LATCH 8'h0c
`define PPC_OFS_PAD 8'h10
`define PPC_OFS_ROUTE_A 8'h14
`define PPC_OFS_ROUTE_B 8'h15
`define PPC_OFS_INT_SEL 8'h16
`define PPC_OFS_M0_MASK 8'h18
`define PPC_OFS_M0_VAL 8'h19
`define PPC_OFS_M1_MASK 8'h1a
`define PPC_OFS_M1_VAL 8'h1b
// ************************************************************
// fields and reset values
// ************************************************************
`define PPC_RA_UART 0
`define PPC_RA_SPI 1
`define PPC_RA_SMB0 2
`define PPC_RA_SYSTEM_CLOCK_OUT 3
`define PPC_RA_CP0 4
`define PPC_RA_COMPARATOR_ASYNC_OUT 5
`define PPC_RA_SMB1 6
`define PPC_RB_WPUD 6
`define PPC_RB_XBAR_EN 7
`define PPC_IS_PIN0 0
`define PPC_IS_POL0 3
`define PPC_IS_PIN1 4
`define PPC_IS_POL1 7
`define PPC_RST_DIGITAL 8'hff
`define PPC_RST_LATCH 8'hff
`define PPC_RST_ZERO 8'h00
// ************************************************************
// routed signal map and fixed pins
// ************************************************************
`define PPC_SIG_OUT 16'h1ff5
`define PPC_SIG_OD 16'h01e0
`define PPC_UART_PIN 4
`define PPC_PIN_VREF 0
`define PPC_PIN_IDAC_A 1
`define PPC_PIN_XTAL_IN 2
`define PPC_PIN_XTAL_OUT 3
`endif

// ### ppc_pkg.sv
// types shared by the port pin cell block
`include "ppc_consts.svh"
package ppc_pkg;
  typedef logic [`PPC_NPIN-1:0] ppc_pins_t;
  typedef logic [`PPC_NSIG-1:0] ppc_sigs_t;
  typedef logic [7:0] ppc_byte_t;
  typedef logic [4:0] ppc_pin_idx_t;
  typedef logic [3:0] ppc_sig_idx_t;
endpackage

// ### ppc_sync.sv
// two-flop synchroniser bank for pad levels
module ppc_sync #(
  parameter int WIDTH = 21
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta;
  // first stage is read only by the second
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // ppc_sync

// ### ppc_xbar.sv
// priority crossbar: first uart on fixed P0.4/P0.5, other routed signals get the lowest free pins
`include "ppc_consts.svh"
module ppc_xbar (
  input wire ppc_pkg::ppc_sigs_t i_sig_en,
  input wire ppc_pkg::ppc_pins_t i_skip,
  output ppc_pkg::ppc_pins_t o_pin_used,
  output ppc_pkg::ppc_sig_idx_t o_pin_sig [`PPC_NPIN],
  output ppc_pkg::ppc_sigs_t o_sig_ok,
  output ppc_pkg::ppc_pin_idx_t o_sig_pin [`PPC_NSIG]
);
  import ppc_pkg::*;
  // walk signals in priority order, each claims one pin
  always_comb begin
    ppc_pins_t taken;
    logic found;
    logic cand;
    taken = '0;
    found = 1'b0;
    cand = 1'b0;
    o_sig_ok = '0;
    for (int p = 0; p < `PPC_NPIN; p++) begin
      o_pin_sig[p] = '0;
    end
    for (int s = 0; s < `PPC_NSIG; s++) begin
      o_sig_pin[s] = '0;
      found = 1'b0;
      if (i_sig_en[s]) begin
        for (int p = 0; p < `PPC_NXBAR; p++) begin
          if (s < 2) begin
            cand = (p == `PPC_UART_PIN + s);
          end else begin
            cand = !taken[p] && !i_skip[p];
          end
          if (!found && cand) begin
            taken[p] = 1'b1;
            found = 1'b1;
            o_pin_sig[p] = 4'(s);
            o_sig_pin[s] = 5'(p);
            o_sig_ok[s] = 1'b1;
          end
        end
      end
    end
    o_pin_used = taken;
  end
endmodule // ppc_xbar

// ### ppc_pad_model.sv
// board-side model of the pads: cell drive, external drive, pull-up, float
module ppc_pad_model
  import ppc_pkg::*;
(
  input wire logic i_clock,
  input wire ppc_pkg::ppc_pins_t i_pad_out,
  input wire ppc_pkg::ppc_pins_t i_pad_oe_n,
  input wire ppc_pkg::ppc_pins_t i_pad_pullup,
  input wire ppc_pkg::ppc_pins_t i_ext_en,
  input wire ppc_pkg::ppc_pins_t i_ext_val,
  output ppc_pkg::ppc_pins_t o_pad_level
);
  timeunit 1ns;
  timeprecision 100ps;
  ppc_pins_t last;
  // remember the last level so an undriven pad can wander off it
  always @(posedge i_clock) begin
    last <= o_pad_level;
  end
  // cell drive wins, else board drive, else pull-up, else floating
  assign o_pad_level = (~i_pad_oe_n & i_pad_out) |
    (i_pad_oe_n & i_ext_en & i_ext_val) |
    (i_pad_oe_n & ~i_ext_en & (i_pad_pullup | ~last));
endmodule // ppc_pad_model

// ### port_pin_cell_assignment_test.sv
// self-checking bench for the port pin cell block
module port_pin_cell_assignment_test
  import ppc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clock, i_rst, i_wr, i_rd, rd_q;
  ppc_byte_t i_addr, i_wdata, o_rdata, exp_q[$];
  ppc_pins_t pad, o_pad_out, o_pad_oe_n, o_pad_pullup, o_analog_sw;
  ppc_pins_t ext_en, ext_val;
  ppc_sigs_t i_periph_out, o_periph_in;
  logic i_vref_en, i_idac_a_en, i_xtal_en, i_xosc_en;
  logic o_int0_event, o_int1_event, o_match_event, o_port_match, o_wake;
  logic [7:0] n_i0, n_i1, n_m, n_w, s_i0, s_i1, s_m, s_w;
  int mismatches, total_checks, cycles;
  integer seed;
  // ************************************************************
  // design and board model
  // ************************************************************
  ppc_top uut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pad_in(pad), .o_pad_out(o_pad_out), .o_pad_oe_n(o_pad_oe_n),
    .o_pad_pullup(o_pad_pullup), .o_analog_sw(o_analog_sw),
    .i_periph_out(i_periph_out), .o_periph_in(o_periph_in),
    .i_vref_en(i_vref_en), .i_idac_a_en(i_idac_a_en),
    .i_xtal_en(i_xtal_en), .i_xosc_en(i_xosc_en),
    .o_int0_event(o_int0_event), .o_int1_event(o_int1_event),
    .o_match_event(o_match_event), .o_port_match(o_port_match),
    .o_wake(o_wake));
  ppc_pad_model board (.i_clock(i_clock), .i_pad_out(o_pad_out),
    .i_pad_oe_n(o_pad_oe_n), .i_pad_pullup(o_pad_pullup),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad_level(pad));
  // ************************************************************
  // clock, watchdog, read and event monitors
  // ************************************************************
  always #2 i_clock = ~i_clock;
  // cut a hang short
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // read data stands the cycle after the strobe: compare oldest note
  always @(posedge i_clock) begin
    rd_q <= i_rd;
    if (rd_q) chk_byte(o_rdata, exp_q.pop_front());
  end
  // count one-cycle event pulses
  always @(posedge i_clock) begin
    n_i0 <= n_i0 + 8'(o_int0_event);
    n_i1 <= n_i1 + 8'(o_int1_event);
    n_m <= n_m + 8'(o_match_event);
    n_w <= n_w + 8'(o_wake);
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input ppc_byte_t got, input ppc_byte_t exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input ppc_byte_t a, input ppc_byte_t d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input ppc_byte_t a, input ppc_byte_t e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_clock);
    i_rd <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge i_clock);
    #1;
  endtask
  // drive enable, level (only while driven) and pull-up of one pin
  task automatic pin(input int n, input logic oe, input logic o,
                     input logic pu);
    chk_bit(o_pad_oe_n[n], oe);
    if (!oe) chk_bit(o_pad_out[n], o);
    chk_bit(o_pad_pullup[n], pu);
  endtask
  task automatic snap();
    s_i0 = n_i0;
    s_i1 = n_i1;
    s_m = n_m;
    s_w = n_w;
  endtask
  task automatic evs(input ppc_byte_t a, input ppc_byte_t b,
                     input ppc_byte_t m);
    chk_byte(n_i0 - s_i0, a);
    chk_byte(n_i1 - s_i1, b);
    chk_byte(n_m - s_m, m);
    chk_byte(n_w - s_w, a + b + m);
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    i_clock = 0; i_rst = 1; i_wr = 0; i_rd = 0; rd_q = 0;
    i_addr = 8'h00; i_wdata = 8'h00; i_periph_out = '0;
    ext_en = '0; ext_val = '0; seed = 32'ha82dd254;
    {i_vref_en, i_idac_a_en, i_xtal_en, i_xosc_en} = 4'h0;
    {n_i0, n_i1, n_m, n_w} = '0;
    mismatches = 0; total_checks = 0; cycles = 0;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    settle();
    // reset values, unmapped slot, pads pulled high
    rd(8'h00, 8'hff);
    rd(8'h04, 8'h00);
    rd(8'h0c, 8'hff);
    rd(8'h15, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h10, 8'hff);
    // crossbar off: nothing drives even in push-pull low
    wr(8'h04, 8'h01);
    wr(8'h0c, 8'hfe);
    settle();
    chk_bit(&o_pad_oe_n, 1'b1);
    // crossbar on: push-pull and open-drain cells
    wr(8'h15, 8'h80);
    settle();
    pin(0, 1'b0, 1'b0, 1'b0);
    wr(8'h0c, 8'hff);
    settle();
    pin(0, 1'b0, 1'b1, 1'b0);
    pin(1, 1'b1, 1'b0, 1'b1);
    wr(8'h0c, 8'hfd);
    settle();
    pin(1, 1'b0, 1'b0, 1'b0);
    wr(8'h0c, 8'hff);
    wr(8'h15, 8'hc0);
    settle();
    pin(1, 1'b1, 1'b0, 1'b0);
    wr(8'h15, 8'h80);
    // board pulls an open-drain high pin low: read shows the pad
    @(posedge i_clock);
    ext_en[1] <= 1'b1;
    settle();
    rd(8'h10, 8'hfd);
    // analog pin: no drive, no pull-up, reads 0
    wr(8'h00, 8'hfb);
    settle();
    pin(2, 1'b1, 1'b0, 1'b0);
    chk_bit(o_analog_sw[2], 1'b1);
    rd(8'h10, 8'hf9);
    // external interrupts on P0.7: int0 active high, int1 active low
    @(posedge i_clock);
    ext_en[8:7] <= 2'b11;
    ext_val[7] <= 1'b1;
    wr(8'h16, 8'h7f);
    settle();
    snap();
    ext_val[7] <= 1'b0;
    settle();
    ext_val[7] <= 1'b1;
    settle();
    evs(8'h01, 8'h01, 8'h00);
    // an analog pin raises no events
    wr(8'h00, 8'h7b);
    settle();
    snap();
    ext_val[7] <= 1'b0;
    settle();
    ext_val[7] <= 1'b1;
    settle();
    evs(8'h00, 8'h00, 8'h00);
    // all of P0 analog, both interrupts on floating P0.0: no events
    wr(8'h16, 8'h00);
    wr(8'h00, 8'h00);
    settle();
    snap();
    settle();
    evs(8'h00, 8'h00, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h00, 8'hfb);
    // port match on P1.0 against value 0
    wr(8'h1a, 8'h01);
    wr(8'h1b, 8'h00);
    settle();
    snap();
    chk_bit(o_port_match, 1'b0);
    ext_val[8] <= 1'b1;
    settle();
    chk_bit(o_port_match, 1'b1);
    evs(8'h00, 8'h00, 8'h01);
    // crossbar routing: uart, smb0, counter io0 with P0.2/P0.3 skipped
    @(posedge i_clock);
    ext_en <= 21'h000020;
    wr(8'h08, 8'h0c);
    wr(8'h04, 8'hff);
    wr(8'h14, 8'h05);
    wr(8'h15, 8'h81);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clock);
      i_periph_out <= 16'($random(seed));
      ext_val[5] <= k[0];
      settle();
      pin(4, 1'b0, i_periph_out[0], 1'b0);
      chk_bit(o_pad_oe_n[5], 1'b1);
      chk_bit(o_periph_in[1], k[0]);
      chk_bit(o_pad_oe_n[0], i_periph_out[5]);
      chk_bit(o_pad_oe_n[1], i_periph_out[6]);
      pin(6, 1'b0, i_periph_out[12], 1'b0);
    end
    // every route_a function on: priority fills free pins in order
    wr(8'h14, 8'h7f);
    settle();
    pin(0, 1'b0, i_periph_out[2], 1'b0);
    pin(1, 1'b1, 1'b0, 1'b1);
    pin(6, 1'b0, i_periph_out[4], 1'b0);
    chk_bit(o_pad_oe_n[7], i_periph_out[5]);
    chk_bit(o_pad_oe_n[14], i_periph_out[12]);
    // fixed analog uses take P0.0 to P0.3 off the digital side
    @(posedge i_clock);
    {i_vref_en, i_idac_a_en, i_xtal_en, i_xosc_en} <= 4'hf;
    settle();
    chk_bit(&o_analog_sw[3:0], 1'b1);
    chk_bit(&o_pad_oe_n[3:0], 1'b1);
    // crossbar off again: all drivers released
    wr(8'h15, 8'h00);
    settle();
    chk_bit(&o_pad_oe_n, 1'b1);
    chk_bit(&o_periph_in, 1'b1);
    settle();
    tally_and_finish();
  end
endmodule // port_pin_cell_assignment_test
